// File: dop_pickup.sv
// directional overcurrent pick-up stage with APB settings
//
// Behaviour
// R1 - magnitude is fundamental RMS, true RMS or peak-to-peak; RMS by default
// R2 - inputs are refreshed and evaluated on a 5 ms time base
// R3 - direction compares positive sequence current angle with voltage angle
// R4 - line-to-line only, no residual: healthy LL voltage, faulty phase current
// R5 - during short-circuit the reference comes from impedance angle
// R6 - below 1 V hold memorised angle 0.5 s, then force 0 degrees
// R7 - memory holds voltage angle from 100 ms before fault start
// R8 - force status Normal/Start/Trip/Blocked applies while forcing enabled
// R9 - force status and magnitude selection are not part of setting groups
// R10 - one pick-up level against all three phases, any phase picks up
// R11 - release only once magnitude falls below 97 % of pick-up level
// R12 - pick-up level 0.10 to 40.00 In in 0.01 steps, default 1.20
// R13 - directional or non-directional characteristic, directional by default
// R14 - non-directional: magnitude pick-up alone qualifies, angle ignored
// R15 - directional: pick-up plus current angle inside sector qualifies
// R16 - sector half-width in 0.1 degree steps, default 88 degrees
// R17 - sector centre -180.0 to 180.0 degrees, default 0, rotates sector
// R18 - leaving sector needs 2 degrees beyond the boundary
// R19 - pick-up settings come from the live active setting group
// R20 - block at pick-up gives Blocked and stops; else Start goes to timing
// R21 - block source asserts block 5 ms before operating delay ends
// R22 - evaluate once per 5 ms update, present two-bit condition code
`timescale 1ns/1ps
module dop_pickup
   import dop_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic active_group,
   input wire logic [2:0][15:0] phase_rms_mag,
   input wire logic [2:0][15:0] phase_trms_mag,
   input wire logic [2:0][15:0] phase_pp_mag,
   input wire logic [11:0] positive_seq_current_angle,
   input wire logic [11:0] positive_seq_voltage_angle,
   input wire logic [15:0] positive_seq_voltage_mag,
   input wire logic line_to_line_voltage_mode,
   input wire logic residual_voltage_present,
   input wire logic [11:0] healthy_ll_voltage_angle,
   input wire logic [11:0] faulty_phase_current_angle,
   input wire logic short_circuit,
   input wire logic [11:0] impedance_angle,
   input wire logic block_in,
   output logic [1:0] condition,
   output logic trip_qualify,
   output logic meas_tick
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic fen;
      logic [1:0] fst;
      logic [1:0] mag_sel;
      logic nondir;
      logic [1:0][11:0] pu;
      logic [1:0][10:0] hw;
      logic [1:0][11:0] ct;
      logic [31:0] prdata;
      logic pslverr;
      logic pready;
      logic [16:0] div_cnt;
      logic tick;
      dop_stage_e stage;
      logic in_sector;
      logic low;
      logic [6:0] hold_cnt;
      logic [11:0] held;
      logic [11:0] ref_angle;
      logic [15:0] op_angle;
      logic [1:0] ref_src;
      logic [1:0] cond;
      logic trip_q;
   } dop_state_s;

   dop_state_s s_reg;
   dop_state_s s_next;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic signed [15:0] sat16(input logic signed [15:0] v,
      input logic signed [15:0] lo, input logic signed [15:0] hi);
      sat16 = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : sat16

   function automatic logic signed [15:0] wrap16(input logic signed [15:0] v);
      logic signed [15:0] r;
      r = v;
      if (r > HALF_TURN)
         r = r - FULL_TURN;
      if (r > HALF_TURN)
         r = r - FULL_TURN;
      if (r < -HALF_TURN)
         r = r + FULL_TURN;
      if (r < -HALF_TURN)
         r = r + FULL_TURN;
      wrap16 = r;
   endfunction : wrap16

   function automatic logic signed [15:0] abs16(input logic signed [15:0] v);
      abs16 = (v < 0) ? -v : v;
   endfunction : abs16

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == OFF_CTRL) || (a == OFF_G0_PU) || (a == OFF_G0_SEC) ||
         (a == OFF_G1_PU) || (a == OFF_G1_SEC) || (a == OFF_STAT) || (a == OFF_ANG);
   endfunction : addr_ok

   // ----------------------------------------------------------------
   // magnitude selection and pick-up comparators
   // ----------------------------------------------------------------
   logic [11:0] pu_act;
   logic [10:0] hw_act;
   logic signed [11:0] ct_act;
   logic [15:0] rel_lvl;
   logic [18:0] rel_prod;
   logic [2:0] over;
   logic [2:0] below;
   logic over_any;
   logic below_all;

   assign pu_act = s_reg.pu[active_group]; // R19
   assign hw_act = s_reg.hw[active_group];
   assign ct_act = s_reg.ct[active_group];
   assign rel_prod = 19'(pu_act) * 19'(RESET_PCT);
   // rounded up so an integer magnitude releases exactly below the 97 % point
   assign rel_lvl = 16'((rel_prod + 19'(PCT_FULL) - 19'h00001) / 19'(PCT_FULL)); // R11

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_phase
         logic [15:0] mag;
         assign mag = (s_reg.mag_sel == MAG_TRMS) ? phase_trms_mag[gi] :
            (s_reg.mag_sel == MAG_PP) ? phase_pp_mag[gi] : phase_rms_mag[gi]; // R1
         assign over[gi] = mag > 16'(pu_act); // R10
         assign below[gi] = mag < rel_lvl; // R11
      end
   endgenerate

   assign over_any = |over; // R10
   assign below_all = &below;

   // ----------------------------------------------------------------
   // reference angle selection and sector check
   // ----------------------------------------------------------------
   logic low_v;
   logic ll_only;
   logic signed [11:0] v_live;
   logic signed [11:0] ref_live;
   logic signed [11:0] ref_eff;
   logic signed [11:0] cur_sel;
   logic [1:0] src_live;
   logic signed [15:0] op_new;
   logic signed [15:0] op_abs;
   logic signed [15:0] hw_wide;
   logic [11:0] mem_rd;

   assign low_v = positive_seq_voltage_mag < LOW_VOLT_CV; // R6
   assign ll_only = line_to_line_voltage_mode && !residual_voltage_present;
   assign v_live = ll_only ? healthy_ll_voltage_angle : positive_seq_voltage_angle; // R4
   assign ref_live = short_circuit ? impedance_angle : v_live; // R5
   assign src_live = short_circuit ? REF_IMP : (ll_only ? REF_LL : REF_U1); // R3
   assign cur_sel = (ll_only && !short_circuit) ? faulty_phase_current_angle :
      positive_seq_current_angle; // R4
   // memory reference is only trusted for a limited time, then 0 degrees
   assign ref_eff = !low_v ? ref_live :
      ((s_reg.hold_cnt < 7'(HOLD_TICKS)) ? s_reg.held : 12'h000); // R6
   assign op_new = wrap16(16'(cur_sel) - 16'(ref_eff) - 16'(ct_act)); // R3 R17
   assign op_abs = abs16(op_new);
   assign hw_wide = 16'(hw_act);

   dop_angle_mem u_mem (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(s_reg.tick && !low_v), // R7
      .wr_data(v_live),
      .rd_data(mem_rd)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   logic dir_ok;
   logic apb_wr;

   assign apb_wr = psel && penable && pwrite && s_reg.pready;

   always_comb
   begin
      s_next = s_reg;
      dir_ok = 1'b0;
      s_next.tick = 1'b0;
      s_next.pready = 1'b1;
      // time base from one clock; front-end refreshes on the same 5 ms grid
      if (s_reg.div_cnt == 17'(TICK_CYC - 1))
      begin
         s_next.div_cnt = 17'h00000;
         s_next.tick = 1'b1; // R2
      end
      else
         s_next.div_cnt = s_reg.div_cnt + 17'h00001;
      // APB read data and error are prepared in the setup cycle
      if (psel && !penable)
      begin
         s_next.pslverr = !addr_ok(paddr);
         s_next.prdata = 32'h00000000;
         unique case (paddr)
            OFF_CTRL: s_next.prdata = 32'({s_reg.nondir, s_reg.mag_sel, s_reg.fst, s_reg.fen});
            OFF_G0_PU: s_next.prdata = 32'(s_reg.pu[0]);
            OFF_G1_PU: s_next.prdata = 32'(s_reg.pu[1]);
            OFF_G0_SEC: s_next.prdata = {4'h0, s_reg.ct[0], 5'h00, s_reg.hw[0]};
            OFF_G1_SEC: s_next.prdata = {4'h0, s_reg.ct[1], 5'h00, s_reg.hw[1]};
            OFF_STAT: s_next.prdata = 32'({s_reg.hold_cnt, s_reg.low, s_reg.in_sector,
               s_reg.ref_src, s_reg.stage, s_reg.cond});
            OFF_ANG: s_next.prdata = {4'h0, s_reg.ref_angle, s_reg.op_angle};
            default: s_next.prdata = 32'h00000000;
         endcase
      end
      if (apb_wr && addr_ok(paddr))
      begin
         unique case (paddr)
            OFF_CTRL:
            begin
               // general settings live outside the groups
               s_next.fen = pwdata[CTRL_FEN]; // R9
               s_next.fst = pwdata[CTRL_FST +: 2];
               s_next.mag_sel = pwdata[CTRL_MAG +: 2];
               s_next.nondir = pwdata[CTRL_NDIR]; // R13
            end
            OFF_G0_PU, OFF_G1_PU:
               s_next.pu[paddr == OFF_G1_PU] =
                  12'(sat16(16'(pwdata[11:0]), PU_MIN, PU_MAX)); // R12
            OFF_G0_SEC, OFF_G1_SEC:
            begin
               s_next.hw[paddr == OFF_G1_SEC] =
                  11'(sat16(16'(pwdata[SEC_HW +: 11]), HW_MIN, HW_MAX)); // R16
               s_next.ct[paddr == OFF_G1_SEC] =
                  12'(sat16(16'(signed'(pwdata[SEC_CT +: 12])), CT_MIN, CT_MAX)); // R17
            end
            default:
               s_next.fen = s_reg.fen;
         endcase
      end
      // one evaluation per measurement update
      if (s_reg.tick)
      begin
         s_next.low = low_v;
         s_next.ref_angle = ref_eff;
         s_next.op_angle = op_new;
         s_next.ref_src = low_v ? REF_MEM : src_live;
         if (low_v)
         begin
            if (s_reg.hold_cnt < 7'(HOLD_TICKS))
               s_next.hold_cnt = s_reg.hold_cnt + 7'h01; // R6
         end
         else
            s_next.hold_cnt = 7'h00;
         // hysteresis keeps a boundary angle from chattering
         s_next.in_sector = (op_abs <= hw_wide) ||
            (s_reg.in_sector && (op_abs <= hw_wide + HYST_DD)); // R16 R18
         unique case (s_reg.stage)
            ST_IDLE:
               if (over_any)
               begin
                  s_next.stage = block_in ? ST_BLOCKED : ST_PICKED; // R20
                  s_next.held = mem_rd; // R7
               end
            ST_PICKED:
               if (below_all)
                  s_next.stage = ST_IDLE; // R11
               else if (block_in)
                  s_next.stage = ST_BLOCKED;
            ST_BLOCKED:
               if (below_all)
                  s_next.stage = ST_IDLE;
         endcase
      end
      dir_ok = s_next.nondir || s_next.in_sector; // R14 R15
      if (s_next.fen)
         s_next.cond = s_next.fst; // R8
      else if (s_next.stage == ST_BLOCKED)
         s_next.cond = COND_BLOCKED; // R20
      else if (s_next.stage == ST_PICKED && dir_ok)
         s_next.cond = COND_START; // R22
      else
         s_next.cond = COND_NORMAL;
      s_next.trip_q = (s_next.cond == COND_START) || (s_next.cond == COND_TRIP);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_reg <= '0;
         s_reg.mag_sel <= MAG_RMS; // R1
         s_reg.pu <= {PU_RST, PU_RST}; // R12
         s_reg.hw <= {HW_RST, HW_RST}; // R16
         s_reg.ct <= {CT_RST, CT_RST}; // R17
         s_reg.pready <= 1'b1;
         s_reg.stage <= ST_IDLE;
         s_reg.cond <= COND_NORMAL;
      end
      else
         s_reg <= s_next;
   end

   assign prdata = s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign condition = s_reg.cond;
   assign trip_qualify = s_reg.trip_q;
   assign meas_tick = s_reg.tick;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic quiet;
   assign quiet = !s_reg.tick && !apb_wr;

   sequence s_eval_idle;
      s_reg.tick && s_reg.stage == ST_IDLE && over_any;
   endsequence
   sequence s_eval_picked;
      s_reg.tick && s_reg.stage == ST_PICKED;
   endsequence

   property p_tick_gap;
      s_reg.tick |=> !s_reg.tick [*8];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("tick too frequent"); // R2

   property p_start;
      s_eval_idle and !block_in |=> s_reg.stage == ST_PICKED;
   endproperty
   a_start: assert property (p_start) else $error("pick-up missed"); // R10 R20

   property p_block;
      s_eval_idle and block_in |=> s_reg.stage == ST_BLOCKED ##0 (s_reg.fen ||
         condition == COND_BLOCKED);
   endproperty
   a_block: assert property (p_block) else $error("block at pick-up ignored"); // R20

   property p_release;
      s_eval_picked and below_all |=> s_reg.stage == ST_IDLE;
   endproperty
   a_release: assert property (p_release) else $error("no release"); // R11

   property p_keep;
      s_eval_picked and !below_all |=> s_reg.stage != ST_IDLE;
   endproperty
   a_keep: assert property (p_keep) else $error("early release"); // R11

   property p_force;
      s_reg.fen && quiet |=> condition == $past(s_reg.fst);
   endproperty
   a_force: assert property (p_force) else $error("force status not applied"); // R8

   property p_nondir;
      s_reg.stage == ST_PICKED && s_reg.nondir && !s_reg.fen && quiet
         |=> condition == COND_START && trip_qualify;
   endproperty
   a_nondir: assert property (p_nondir) else $error("nondirectional start lost"); // R14

   property p_dir;
      s_reg.stage == ST_PICKED && !s_reg.nondir && !s_reg.in_sector && !s_reg.fen && quiet
         |=> condition == COND_NORMAL && !trip_qualify;
   endproperty
   a_dir: assert property (p_dir) else $error("start outside sector"); // R15

   property p_mem_zero;
      s_reg.tick && low_v && s_reg.hold_cnt >= 7'(HOLD_TICKS) |=> s_reg.ref_angle == 12'h000;
   endproperty
   a_mem_zero: assert property (p_mem_zero) else $error("reference not forced to 0"); // R6

   property p_mem_held;
      s_reg.tick && low_v && s_reg.hold_cnt < 7'(HOLD_TICKS)
         |=> s_reg.ref_angle == $past(s_reg.held);
   endproperty
   a_mem_held: assert property (p_mem_held) else $error("memory angle not used"); // R6 R7

   property p_hyst;
      s_reg.tick && s_reg.in_sector && op_abs <= hw_wide + HYST_DD |=> s_reg.in_sector;
   endproperty
   a_hyst: assert property (p_hyst) else $error("sector left inside hysteresis"); // R18

   property p_pu_range;
      apb_wr && paddr == OFF_G0_PU |=> s_reg.pu[0] >= 12'(PU_MIN) && s_reg.pu[0] <= 12'(PU_MAX);
   endproperty
   a_pu_range: assert property (p_pu_range) else $error("pick-up level out of range"); // R12
endmodule : dop_pickup

// File: dop_pkg.sv
// constants and types of the directional overcurrent pick-up stage
package dop_pkg;
   // ----------------------------------------------------------------
   // time base
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_MS = 5;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int HOLD_MS = 500;
   localparam int HOLD_TICKS = HOLD_MS / TICK_MS;
   localparam int PREF_MS = 100;
   localparam int PREF_TICKS = PREF_MS / TICK_MS;
   // ----------------------------------------------------------------
   // measurement thresholds (current 0.01 In, voltage 0.01 V, angle 0.1 deg)
   // ----------------------------------------------------------------
   localparam logic [15:0] LOW_VOLT_CV = 16'h0064;
   localparam logic [6:0] RESET_PCT = 7'h61;
   localparam logic [6:0] PCT_FULL = 7'h64;
   localparam logic signed [15:0] HYST_DD = 16'h0014;
   localparam logic signed [15:0] HALF_TURN = 16'h0708;
   localparam logic signed [15:0] FULL_TURN = 16'h0E10;
   // ----------------------------------------------------------------
   // setting limits and reset values
   // ----------------------------------------------------------------
   localparam logic signed [15:0] PU_MIN = 16'h000A;
   localparam logic signed [15:0] PU_MAX = 16'h0FA0;
   localparam logic [11:0] PU_RST = 12'h078;
   localparam logic signed [15:0] HW_MIN = 16'h000A;
   localparam logic signed [15:0] HW_MAX = 16'h06A4;
   localparam logic [10:0] HW_RST = 11'h370;
   localparam logic signed [15:0] CT_MIN = 16'hF8F8;
   localparam logic signed [15:0] CT_MAX = 16'h0708;
   localparam logic [11:0] CT_RST = 12'h000;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_G0_PU = 8'h04;
   localparam logic [7:0] OFF_G0_SEC = 8'h08;
   localparam logic [7:0] OFF_G1_PU = 8'h0C;
   localparam logic [7:0] OFF_G1_SEC = 8'h10;
   localparam logic [7:0] OFF_STAT = 8'h14;
   localparam logic [7:0] OFF_ANG = 8'h18;
   localparam int CTRL_FEN = 0;
   localparam int CTRL_FST = 1;
   localparam int CTRL_MAG = 3;
   localparam int CTRL_NDIR = 5;
   localparam int SEC_HW = 0;
   localparam int SEC_CT = 16;
   localparam int ANG_REF = 16;
   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] COND_NORMAL = 2'h0;
   localparam logic [1:0] COND_START = 2'h1;
   localparam logic [1:0] COND_TRIP = 2'h2;
   localparam logic [1:0] COND_BLOCKED = 2'h3;
   localparam logic [1:0] MAG_RMS = 2'h0;
   localparam logic [1:0] MAG_TRMS = 2'h1;
   localparam logic [1:0] MAG_PP = 2'h2;
   localparam logic [1:0] REF_U1 = 2'h0;
   localparam logic [1:0] REF_LL = 2'h1;
   localparam logic [1:0] REF_IMP = 2'h2;
   localparam logic [1:0] REF_MEM = 2'h3;
   typedef enum logic [1:0] {ST_IDLE, ST_PICKED, ST_BLOCKED} dop_stage_e;
endpackage : dop_pkg

// File: dop_angle_mem.sv
// pre-fault voltage angle history, one entry per measurement tick with the voltage not below 1 V
`timescale 1ns/1ps
module dop_angle_mem
   import dop_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   input wire logic [11:0] wr_data,
   output logic [11:0] rd_data
);
   typedef struct packed {
      logic [4:0] ptr;
      logic filled;
      logic [11:0] rd;
   } dop_mem_s;

   logic [11:0] mem [PREF_TICKS];
   dop_mem_s m_reg;
   dop_mem_s m_next;

   // oldest entry is read just before it is overwritten; empty slots read 0
   always_comb
   begin
      m_next = m_reg;
      if (wr_en)
      begin
         m_next.rd = m_reg.filled ? mem[m_reg.ptr] : 12'h000;
         if (m_reg.ptr == 5'(PREF_TICKS - 1))
         begin
            m_next.ptr = 5'h00;
            m_next.filled = 1'b1;
         end
         else
            m_next.ptr = m_reg.ptr + 5'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         m_reg <= '0;
      else
         m_reg <= m_next;
   end

   always_ff @(posedge pclk)
   begin
      if (wr_en)
         mem[m_reg.ptr] <= wr_data;
   end

   assign rd_data = m_reg.rd;
endmodule : dop_angle_mem

// File: dop_meas_model.sv
// measurement front-end and blocking matrix model
`timescale 1ns/1ps
module dop_meas_model
   import dop_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic meas_tick,
   input wire logic [15:0] t_mag,
   input wire logic [1:0] t_kind,
   input wire logic [1:0] t_ph,
   input wire logic t_blk,
   output logic [2:0][15:0] rms,
   output logic [2:0][15:0] trms,
   output logic [2:0][15:0] pp,
   output logic block_in
);
   // refresh only at the tick edge, so values hold through a tick
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rms <= '0;
         trms <= '0;
         pp <= '0;
         block_in <= 1'h0;
      end
      else if (meas_tick)
      begin
         for (int i = 0; i < 3; i++)
         begin
            rms[i] <= (t_kind == MAG_RMS && i == t_ph) ? t_mag : 16'h0000;
            trms[i] <= (t_kind == MAG_TRMS && i == t_ph) ? t_mag : 16'h0000;
            pp[i] <= (t_kind == MAG_PP && i == t_ph) ? t_mag : 16'h0000;
         end
         block_in <= t_blk;
      end
   end
endmodule : dop_meas_model

// File: tb_directional_overcurrent_pickup.sv
// self-checking bench of the directional overcurrent pick-up stage
`timescale 1ns/1ps
module tb_directional_overcurrent_pickup
   import dop_pkg::*;
;
   typedef struct packed {
      logic [5:0] ctl;
      logic g;
      logic [15:0] m;
      logic [1:0] k;
      logic [11:0] a;
      logic b;
      logic [1:0] c;
   } dop_row_s;
   localparam dop_row_s ROWS [23] = '{
      '{6'h00, 1'h0, 16'h0079, 2'h0, 12'h000, 1'h0, 2'h1},
      '{6'h00, 1'h0, 16'h0075, 2'h0, 12'h000, 1'h0, 2'h1},
      '{6'h00, 1'h0, 16'h0074, 2'h0, 12'h000, 1'h0, 2'h0},
      '{6'h00, 1'h0, 16'h0078, 2'h0, 12'h5DC, 1'h0, 2'h0},
      '{6'h00, 1'h0, 16'h00C8, 2'h0, 12'h37A, 1'h0, 2'h0},
      '{6'h00, 1'h0, 16'h00C8, 2'h0, 12'h370, 1'h0, 2'h1},
      '{6'h00, 1'h0, 16'h00C8, 2'h0, 12'h383, 1'h0, 2'h1},
      '{6'h00, 1'h0, 16'h00C8, 2'h0, 12'h385, 1'h0, 2'h0},
      '{6'h20, 1'h0, 16'h00C8, 2'h0, 12'h5DC, 1'h0, 2'h1},
      '{6'h08, 1'h0, 16'h00C8, 2'h1, 12'h000, 1'h0, 2'h1},
      '{6'h08, 1'h0, 16'h00C8, 2'h0, 12'h000, 1'h0, 2'h0},
      '{6'h10, 1'h0, 16'h00C8, 2'h2, 12'h000, 1'h0, 2'h1},
      '{6'h18, 1'h0, 16'h00C8, 2'h0, 12'h000, 1'h0, 2'h1},
      '{6'h00, 1'h0, 16'h0000, 2'h0, 12'h000, 1'h0, 2'h0},
      '{6'h00, 1'h0, 16'h00C8, 2'h0, 12'h000, 1'h1, 2'h3},
      '{6'h00, 1'h0, 16'h0000, 2'h0, 12'h000, 1'h0, 2'h0},
      '{6'h05, 1'h0, 16'h0000, 2'h0, 12'h000, 1'h0, 2'h2},
      '{6'h07, 1'h0, 16'h0000, 2'h0, 12'h000, 1'h0, 2'h3},
      '{6'h03, 1'h0, 16'h0000, 2'h0, 12'h000, 1'h0, 2'h1},
      '{6'h06, 1'h0, 16'h0000, 2'h0, 12'h000, 1'h0, 2'h0},
      '{6'h00, 1'h1, 16'h00FA, 2'h0, 12'h000, 1'h0, 2'h0},
      '{6'h00, 1'h1, 16'h012E, 2'h0, 12'hAEC, 1'h0, 2'h1},
      '{6'h00, 1'h0, 16'h012E, 2'h0, 12'hAEC, 1'h0, 2'h0}};
   logic pclk, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd;
   logic grp = 1'h0, vmode = 1'h0, resid = 1'h0, sc = 1'h0, t_blk = 1'h0, er;
   logic [11:0] cang = 12'h000, vang = 12'h000, hang = 12'h000, imp = 12'h000, fang = 12'h000;
   logic [15:0] vmag = 16'h2710, t_mag = 16'h0000;
   logic [1:0] t_kind = 2'h0, t_ph = 2'h0, condition;
   wire logic [2:0][15:0] rms, trms, pp;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, blk, tq, meas_tick;
   int miscompares, check_count, cyc;
   dop_row_s r;

   dop_meas_model fe (.pclk(pclk), .presetn(presetn), .meas_tick(meas_tick), .t_mag(t_mag),
      .t_kind(t_kind), .t_ph(t_ph), .t_blk(t_blk), .rms(rms), .trms(trms), .pp(pp),
      .block_in(blk));
   dop_pickup #(.TICK_CYC(16)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .active_group(grp), .phase_rms_mag(rms),
      .phase_trms_mag(trms), .phase_pp_mag(pp), .positive_seq_current_angle(cang),
      .positive_seq_voltage_angle(vang), .positive_seq_voltage_mag(vmag),
      .line_to_line_voltage_mode(vmode), .residual_voltage_present(resid),
      .healthy_ll_voltage_angle(hang), .faulty_phase_current_angle(fang),
      .short_circuit(sc), .impedance_angle(imp), .block_in(blk), .condition(condition),
      .trip_qualify(tq), .meas_tick(meas_tick));

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e)
      begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_of_test

   // release happens after the sampled edge, never earlier
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask : apb

   task automatic tick();
      do @(negedge pclk); while (meas_tick !== 1'h1);
      @(posedge pclk);
   endtask : tick

   initial
   begin
      pclk = 1'h0;
      forever #25 pclk = ~pclk;
   end

   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         end_of_test();
      end
   end

   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      apb(1'h0, OFF_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'h0, OFF_G0_PU, 32'h0);
      chk(rd, 32'h78);
      apb(1'h0, OFF_G0_SEC, 32'h0);
      chk(rd, 32'h370);
      apb(1'h0, 8'h1C, 32'h0);
      chk({er, rd[30:0]}, 32'h80000000);
      apb(1'h1, OFF_G1_PU, 32'hFFF);
      apb(1'h0, OFF_G1_PU, 32'h0);
      chk(rd, 32'hFA0);
      apb(1'h1, OFF_G0_PU, 32'h5);
      apb(1'h0, OFF_G0_PU, 32'h0);
      chk(rd, 32'hA);
      apb(1'h1, OFF_G0_PU, 32'h78);
      apb(1'h1, OFF_G1_PU, 32'h12C);
      apb(1'h1, OFF_G1_SEC, 32'h0E3E0370);
      foreach (ROWS[i])
      begin
         r = ROWS[i];
         @(posedge pclk);
         apb(1'h1, OFF_CTRL, {26'h0, r.ctl});
         t_mag <= r.m;
         t_kind <= r.k;
         t_ph <= 2'(i % 3);
         t_blk <= r.b;
         cang <= r.a;
         grp <= r.g;
         tick();
         tick();
         @(negedge pclk);
         chk({30'h0, condition}, {30'h0, r.c});
         chk({31'h0, tq}, {31'h0, r.c == COND_START || r.c == COND_TRIP});
      end
      @(posedge pclk);
      apb(1'h1, OFF_CTRL, 32'h0);
      t_mag <= 16'h0000;
      cang <= 12'h000;
      vmode <= 1'h1;
      hang <= 12'h258;
      fang <= 12'h064;
      repeat (3) tick();
      apb(1'h0, OFF_ANG, 32'h0);
      chk({20'h0, rd[27:16]}, 32'h258);
      chk({16'h0, rd[15:0]}, 32'hFE0C);
      resid <= 1'h1;
      repeat (2) tick();
      apb(1'h0, OFF_ANG, 32'h0);
      chk({20'h0, rd[27:16]}, 32'h0);
      sc <= 1'h1;
      imp <= 12'h1C2;
      repeat (2) tick();
      apb(1'h0, OFF_ANG, 32'h0);
      chk({20'h0, rd[27:16]}, 32'h1C2);
      sc <= 1'h0;
      vmode <= 1'h0;
      vang <= 12'h12C;
      repeat (25) tick();
      // live angle moves as the fault starts; the pre-fault one must stay
      vang <= 12'h2BC;
      vmag <= 16'h0032;
      t_mag <= 16'h00C8;
      repeat (40) tick();
      apb(1'h0, OFF_ANG, 32'h0);
      chk({20'h0, rd[27:16]}, 32'h12C);
      repeat (70) tick();
      apb(1'h0, OFF_ANG, 32'h0);
      chk({20'h0, rd[27:16]}, 32'h0);
      apb(1'h1, OFF_CTRL, 32'h3);
      tick();
      presetn <= 1'h0;
      @(negedge pclk);
      chk({27'h0, pready, meas_tick, tq, condition}, 32'h10);
      @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      apb(1'h0, OFF_CTRL, 32'h0);
      chk(rd, 32'h0);
      end_of_test();
   end
endmodule : tb_directional_overcurrent_pickup
